// file: dsa_pkg.sv
package dsa_pkg;
  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MEM_CYCLE_US = 10;
  localparam int SLOT_CLKS = MEM_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] SLOT_LAST = 8'(SLOT_CLKS - 1);
  localparam logic [6:0] HALF_LAST = 7'(SLOT_CLKS / 2 - 1);
  localparam logic [15:0] BASE_HALF = 16'h000D; // 6.5 cycles in half cycles
  localparam logic [3:0] DIV_MAX = 4'h9;
  // ***********************************************
  // Register map and fields
  // ***********************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_PADDR = 12'h004;
  localparam logic [11:0] REG_QADDR = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;
  localparam int CTRL_GO = 8;
  localparam logic [7:0] OP_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // ***********************************************
  // Operation codes, two decimal digits
  // ***********************************************
  localparam logic [7:0] OP_ADD_FIELD = 8'h21;
  localparam logic [7:0] OP_ADD_LITERAL = 8'h11;
  localparam logic [7:0] OP_SUB_FIELD = 8'h22;
  localparam logic [7:0] OP_SUB_LITERAL = 8'h12;
  localparam logic [7:0] OP_PRODUCT = 8'h23;
  localparam logic [7:0] OP_PRODUCT_LITERAL = 8'h13;
  localparam logic [7:0] OP_QUOTIENT = 8'h29;
  localparam logic [7:0] OP_QUOTIENT_LITERAL = 8'h19;
  localparam logic [7:0] OP_LOAD_DIVIDEND = 8'h28;
  localparam logic [7:0] OP_LOAD_DIVIDEND_LITERAL = 8'h18;
  localparam logic [7:0] OP_BRANCH_ON_FLAG = 8'h46;
  localparam logic [7:0] OP_BRANCH_UNLESS_FLAG = 8'h47;
  // ***********************************************
  // Storage areas
  // ***********************************************
  localparam logic [15:0] TABLE_LO = 16'h0064;
  localparam logic [15:0] TABLE_HI = 16'h012B;
  localparam logic [15:0] PROD_LO = 16'h0050;
  localparam logic [15:0] PROD_HI = 16'h0063;
  typedef enum logic [2:0] {
    DSA_IDLE = 3'b000,
    DSA_RD = 3'b001,
    DSA_WAITD = 3'b010,
    DSA_CALC = 3'b011,
    DSA_GAP = 3'b100,
    DSA_FIN = 3'b101
  } dsa_state_t;
endpackage

// file: dsa_top.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module dsa_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic console_rst,
  input wire logic div_sub_ok,
  input wire logic div_digit_end,
  output logic mem_rd,
  output logic mem_we,
  output logic [15:0] mem_p_addr,
  output logic [15:0] mem_q_addr,
  output logic [4:0] mem_wdata,
  input wire logic [4:0] mem_p_rdata,
  input wire logic [4:0] mem_q_rdata,
  output logic busy
);
  dsa_pkg::dsa_state_t state_r;
  logic [7:0] slot_r;
  logic [6:0] tick_r;
  logic [15:0] half_r, dp_r, dq_r, pa_r, qa_r, p_a_r, q_a_r;
  logic [7:0] op_r;
  logic [3:0] divcnt_r;
  logic pready_r, first_r, qend_r, carry_r, comp_r, rc_r, rcd_r, end_r;
  logic need_rc_r, sub_r, mul_r, div_r, psign_r, nz_r, hp_r, ez_r, chk_r;
  logic psn_r, badop_r, busy_r;

  // ***********************************************
  // APB slave
  // ***********************************************
  // One wait state; write and read data land on the completing edge
  wire acc_w = psel & penable & ~pready_r;
  wire fire_w = psel & penable & pready_r;
  wire wr_w = fire_w & pwrite;
  wire sel_ctrl = paddr == dsa_pkg::REG_CTRL;
  wire sel_pa = paddr == dsa_pkg::REG_PADDR;
  wire sel_qa = paddr == dsa_pkg::REG_QADDR;
  wire sel_st = paddr == dsa_pkg::REG_STAT;
  wire mapped_w = sel_ctrl | sel_pa | sel_qa | sel_st;
  wire [31:0] stat_w = {25'h0, badop_r, rcd_r, psn_r, chk_r, ez_r, hp_r, busy_r};
  wire [31:0] rd_w = sel_ctrl ? {24'h0, op_r} :
                     sel_pa ? {16'h0, pa_r} :
                     sel_qa ? {16'h0, qa_r} :
                     sel_st ? stat_w : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      pready_r <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready_r <= acc_w;
      pslverr <= acc_w & ~mapped_w;
      prdata <= acc_w ? rd_w : 32'h0;
    end
  end
  assign pready = pready_r;

  // ***********************************************
  // Opcode decode
  // ***********************************************
  // Operands are locked while busy so a walk never sees moving bases
  wire [7:0] opw = pwdata[7:0];
  wire is_add = opw == dsa_pkg::OP_ADD_FIELD || opw == dsa_pkg::OP_ADD_LITERAL;
  wire is_sub = opw == dsa_pkg::OP_SUB_FIELD || opw == dsa_pkg::OP_SUB_LITERAL;
  wire is_mul = opw == dsa_pkg::OP_PRODUCT || opw == dsa_pkg::OP_PRODUCT_LITERAL;
  wire is_div = opw == dsa_pkg::OP_QUOTIENT || opw == dsa_pkg::OP_QUOTIENT_LITERAL;
  wire is_ldv = opw == dsa_pkg::OP_LOAD_DIVIDEND || opw == dsa_pkg::OP_LOAD_DIVIDEND_LITERAL;
  wire is_br = opw == dsa_pkg::OP_BRANCH_ON_FLAG || opw == dsa_pkg::OP_BRANCH_UNLESS_FLAG;
  wire run_w = is_add | is_sub | is_mul | is_div;
  wire arith_w = run_w | is_ldv;
  wire go_w = wr_w & sel_ctrl & pwdata[dsa_pkg::CTRL_GO] & ~busy_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      op_r <= dsa_pkg::OP_RST;
      pa_r <= dsa_pkg::ADDR_RST;
      qa_r <= dsa_pkg::ADDR_RST;
      badop_r <= 1'b0;
    end else if (wr_w & ~busy_r) begin
      if (sel_ctrl) begin
        op_r <= opw;
      end
      if (sel_pa) begin
        pa_r <= pwdata[15:0];
      end
      if (sel_qa) begin
        qa_r <= pwdata[15:0];
      end
      if (go_w) begin
        badop_r <= ~(arith_w | is_br);
      end
    end
  end

  // ***********************************************
  // Digit datapath
  // ***********************************************
  // Sign rides on the units flag; the end flag sits on the top digit
  wire [3:0] pd_w = mem_p_rdata[3:0];
  wire pf_w = mem_p_rdata[4];
  wire qf_w = mem_q_rdata[4];
  wire [3:0] qd_w = qend_r ? 4'h0 : mem_q_rdata[3:0];
  wire comp_w = first_r ? (sub_r ^ pf_w ^ qf_w) : comp_r;
  wire [3:0] qx_w = comp_w ? 4'h9 - qd_w : qd_w;
  wire [3:0] opa_w = rc_r ? 4'h0 : pd_w;
  wire [3:0] opb_w = rc_r ? 4'h9 - pd_w : qx_w;
  // Units carry-in of one turns the nines complement into tens
  wire cin_w = first_r ? (rc_r | comp_w) : carry_r;
  wire [4:0] sum_w = {1'b0, opa_w} + {1'b0, opb_w} + {4'h0, cin_w};
  wire cout_w = sum_w > 5'h09;
  wire [4:0] dig_w = cout_w ? sum_w - 5'h0A : sum_w;
  wire pend_w = ~first_r & pf_w;
  wire qend_now_w = ~first_r & qf_w & ~qend_r;
  wire qlong_w = pend_w & ~rc_r & ~qend_r & ~qend_now_w;
  wire wflag_w = (first_r & rc_r) ? ~psign_r : pf_w;
  wire tab_w = p_a_r >= dsa_pkg::TABLE_LO && p_a_r <= dsa_pkg::TABLE_HI;
  wire md_w = mul_r | div_r;
  wire we_w = (~md_w | (mul_r & ~first_r)) & ~tab_w;
  wire [4:0] wd_w = md_w ? 5'h00 : {wflag_w, dig_w[3:0]};
  wire calc_w = state_r == dsa_pkg::DSA_CALC;
  wire slot_end_w = slot_r == dsa_pkg::SLOT_LAST;
  wire rcq_w = need_rc_r & ~rc_r;
  wire mdone_w = div_r | (mul_r & ~first_r & p_a_r == dsa_pkg::PROD_LO);
  // Formula time in half cycles; a recomplement pass adds two per P digit
  wire [15:0] rc_half_w = rcd_r ? {dp_r[14:0], 1'b0} : 16'h0000;
  wire [15:0] target_w = dsa_pkg::BASE_HALF + dq_r + {dp_r[14:0], 1'b0} + rc_half_w;
  wire time_ok_w = md_w | (half_r >= target_w);
  wire fin_w = state_r == dsa_pkg::DSA_FIN && time_ok_w;

  // Walk, carries and sign capture
  always_ff @(posedge clk) begin
    if (srst) begin
      p_a_r <= dsa_pkg::ADDR_RST;
      q_a_r <= dsa_pkg::ADDR_RST;
      {first_r, qend_r, carry_r, comp_r, rc_r, rcd_r} <= 6'h00;
      {end_r, need_rc_r, sub_r, mul_r, div_r, psign_r, nz_r} <= 7'h00;
      dp_r <= 16'h0000;
      dq_r <= 16'h0000;
    end else if (go_w) begin
      p_a_r <= pa_r;
      q_a_r <= qa_r;
      {first_r, qend_r, carry_r, rc_r, rcd_r, end_r, need_rc_r, nz_r} <= 8'h80;
      sub_r <= is_sub;
      mul_r <= is_mul;
      div_r <= is_div;
      dp_r <= 16'h0000;
      dq_r <= 16'h0000;
    end else if (calc_w & md_w) begin
      first_r <= 1'b0;
      end_r <= mdone_w;
      p_a_r <= first_r ? dsa_pkg::PROD_HI : p_a_r - 16'h0001;
    end else if (calc_w) begin
      first_r <= 1'b0;
      carry_r <= cout_w;
      nz_r <= nz_r | (dig_w != 5'h00);
      p_a_r <= p_a_r - 16'h0001;
      q_a_r <= q_a_r - 16'h0001;
      if (first_r & ~rc_r) begin
        comp_r <= comp_w;
        psign_r <= pf_w;
      end
      if (~rc_r) begin
        dp_r <= dp_r + 16'h0001;
        dq_r <= qend_r ? dq_r : dq_r + 16'h0001;
        qend_r <= qend_r | qend_now_w;
      end
      if (pend_w) begin
        end_r <= 1'b1;
        // No carry after complement-add means second magnitude was larger
        need_rc_r <= rc_r ? need_rc_r : comp_r & ~cout_w;
      end
    end else if (state_r == dsa_pkg::DSA_GAP && slot_end_w && end_r && rcq_w) begin
      rc_r <= 1'b1;
      rcd_r <= 1'b1;
      p_a_r <= pa_r;
      first_r <= 1'b1;
      end_r <= 1'b0;
      nz_r <= 1'b0;
    end
  end

  // ***********************************************
  // Sequencer and storage port
  // ***********************************************
  // Every access owns a whole memory slot, idle after the write
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= dsa_pkg::DSA_IDLE;
    end else begin
      case (state_r)
        dsa_pkg::DSA_IDLE: if (go_w & run_w) begin
          state_r <= dsa_pkg::DSA_RD;
        end
        dsa_pkg::DSA_RD: state_r <= dsa_pkg::DSA_WAITD;
        dsa_pkg::DSA_WAITD: state_r <= dsa_pkg::DSA_CALC;
        dsa_pkg::DSA_CALC: state_r <= dsa_pkg::DSA_GAP;
        dsa_pkg::DSA_GAP: if (slot_end_w) begin
          state_r <= (end_r & ~rcq_w) ? dsa_pkg::DSA_FIN : dsa_pkg::DSA_RD;
        end
        dsa_pkg::DSA_FIN: if (time_ok_w) begin
          state_r <= dsa_pkg::DSA_IDLE;
        end
        default: state_r <= dsa_pkg::DSA_IDLE;
      endcase
    end
  end

  // Slot position restarts with each read
  always_ff @(posedge clk) begin
    if (srst || state_r == dsa_pkg::DSA_IDLE || (state_r == dsa_pkg::DSA_GAP && slot_end_w)) begin
      slot_r <= 8'h00;
    end else begin
      slot_r <= slot_r + 8'h01;
    end
  end

  // Address held one extra cycle so the write hits the digit just read
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_rd <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 5'h00;
      mem_p_addr <= dsa_pkg::ADDR_RST;
      mem_q_addr <= dsa_pkg::ADDR_RST;
    end else begin
      mem_rd <= state_r == dsa_pkg::DSA_RD;
      mem_we <= calc_w & we_w;
      mem_wdata <= calc_w ? wd_w : 5'h00;
      mem_p_addr <= p_a_r;
      mem_q_addr <= q_a_r;
    end
  end

  // ***********************************************
  // Execution time
  // ***********************************************
  // Half-cycle ticks; finish of an add or subtract is held until the formula time has passed

  always_ff @(posedge clk) begin
    if (srst || go_w) begin
      tick_r <= 7'h00;
      half_r <= 16'h0000;
    end else if (busy_r) begin
      tick_r <= (tick_r == dsa_pkg::HALF_LAST) ? 7'h00 : tick_r + 7'h01;
      half_r <= (tick_r == dsa_pkg::HALF_LAST) ? half_r + 16'h0001 : half_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (go_w & run_w) | (busy_r & ~fin_w);
    end
  end
  assign busy = busy_r;

  // ***********************************************
  // Indicators
  // ***********************************************
  // Final sign flips only when a recomplement pass ran
  wire fsign_w = psign_r ^ rcd_r;
  wire div_set_w = div_sub_ok & (divcnt_r == dsa_pkg::DIV_MAX);
  wire carry_set_w = calc_w & ~md_w & ~rc_r & pend_w & ~comp_w & cout_w;
  wire qlong_set_w = calc_w & ~md_w & qlong_w;
  wire chk_set_w = div_set_w | carry_set_w | qlong_set_w;
  wire chk_clr_w = console_rst | (go_w & is_br);

  always_ff @(posedge clk) begin
    if (srst) begin
      hp_r <= 1'b0;
      ez_r <= 1'b0;
    end else if (go_w & arith_w) begin
      hp_r <= 1'b1;
      ez_r <= 1'b1;
    end else if (fin_w & ~md_w) begin
      hp_r <= nz_r & ~fsign_w;
      ez_r <= ~nz_r;
    end else if (console_rst) begin
      hp_r <= 1'b0;
      ez_r <= 1'b0;
    end
  end

  // Set beats clear so a late overflow is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      chk_r <= 1'b0;
    end else begin
      chk_r <= chk_set_w | (chk_r & ~chk_clr_w);
    end
  end

  // Good subtractions per quotient digit, saturating at the limit
  always_ff @(posedge clk) begin
    if (srst || div_digit_end) begin
      divcnt_r <= 4'h0;
    end else if (div_sub_ok && divcnt_r != dsa_pkg::DIV_MAX) begin
      divcnt_r <= divcnt_r + 4'h1;
    end
  end

  // Product or quotient sign from factor units flags
  always_ff @(posedge clk) begin
    if (srst) begin
      psn_r <= 1'b0;
    end else if (calc_w & md_w & first_r) begin
      psn_r <= pf_w ^ qf_w;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  a_start_hp: assert property (@(posedge clk) disable iff (srst) go_w && arith_w |=> hp_r)
    else $error("positive flag not set at start");
  a_start_ez: assert property (@(posedge clk) disable iff (srst) go_w && arith_w |=> ez_r)
    else $error("zero flag not set at start");
  a_chk_kept: assert property (@(posedge clk) disable iff (srst)
    go_w && arith_w && !console_rst && !div_set_w |=> chk_r == $past(chk_r))
    else $error("check flag changed at arithmetic start");
  a_branch_clr: assert property (@(posedge clk) disable iff (srst)
    go_w && is_br && !div_set_w |=> !chk_r)
    else $error("branch did not clear check flag");
  a_console_clr: assert property (@(posedge clk) disable iff (srst)
    console_rst && !busy_r && !go_w && !div_set_w |=> !hp_r && !ez_r && !chk_r)
    else $error("console reset left a flag on");
  a_table_safe: assert property (@(posedge clk) disable iff (srst)
    mem_we |-> !(mem_p_addr >= dsa_pkg::TABLE_LO && mem_p_addr <= dsa_pkg::TABLE_HI))
    else $error("write into multiply table");
  a_prod_area: assert property (@(posedge clk) disable iff (srst)
    mem_we && mul_r |-> mem_p_addr >= dsa_pkg::PROD_LO && mem_p_addr <= dsa_pkg::PROD_HI)
    else $error("product write outside product area");
  a_slot_gap: assert property (@(posedge clk) disable iff (srst) mem_rd |=> !mem_rd [*8])
    else $error("storage accesses too close");
  a_div_over: assert property (@(posedge clk) disable iff (srst) div_set_w |=> chk_r)
    else $error("tenth subtraction did not set check");
  a_walk_down: assert property (@(posedge clk) disable iff (srst)
    calc_w && !md_w && !go_w |=> p_a_r == $past(p_a_r) - 16'h0001)
    else $error("field walk not descending");
  a_carry_chk: assert property (@(posedge clk) disable iff (srst) carry_set_w |=> chk_r)
    else $error("lost carry did not set check");
endmodule // dsa_top
`default_nettype wire

// file: dsa_core_store.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************
// Digit storage on the far side of the unit
// ***********************************************
module dsa_core_store (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [15:0] mem_p_addr,
  input wire logic [15:0] mem_q_addr,
  input wire logic [4:0] mem_wdata,
  output logic [4:0] mem_p_rdata,
  output logic [4:0] mem_q_rdata,
  output logic [7:0] table_wr
);
  logic [4:0] mem [0:1023];

  // Empty storage, read lines start low and toggle on every clock that has no read
  initial begin
    table_wr = 8'h00;
    mem_p_rdata = 5'h00;
    mem_q_rdata = 5'h00;
    for (int i = 0; i < 1024; i++) mem[i] = 5'h00;
  end

  // One access per memory slot, registered read; lines toggle outside a read
  // so that a late sample of stale data cannot pass as good data
  always @(posedge clk) begin
    mem_p_rdata <= mem_rd ? mem[mem_p_addr[9:0]] : ~mem_p_rdata;
    mem_q_rdata <= mem_rd ? mem[mem_q_addr[9:0]] : ~mem_q_rdata;
    if (mem_we) begin
      mem[mem_p_addr[9:0]] <= mem_wdata;
      // Table area must stay intact, every write there is counted
      if (mem_p_addr >= dsa_pkg::TABLE_LO && mem_p_addr <= dsa_pkg::TABLE_HI) begin
        table_wr <= table_wr + 8'h01;
      end
    end
  end
endmodule // dsa_core_store
`default_nettype wire

// file: dsa_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************
// Bench for the decimal serial arithmetic unit
// ***********************************************
module dsa_tb_top;
  logic clk, srst, psel, penable, pwrite, console_rst, div_sub_ok, div_digit_end;
  logic [11:0] paddr;
  logic [31:0] pwdata, st, q;
  logic err, chk_e;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, mem_rd, mem_we, busy;
  wire logic [15:0] mem_p_addr, mem_q_addr;
  wire logic [4:0] mem_wdata, mem_p_rdata, mem_q_rdata;
  wire logic [7:0] table_wr;
  int n_fail, n_compared, cyc, t;

  dsa_top dsa_top_inst (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .console_rst(console_rst),
    .div_sub_ok(div_sub_ok), .div_digit_end(div_digit_end), .mem_rd(mem_rd),
    .mem_we(mem_we), .mem_p_addr(mem_p_addr), .mem_q_addr(mem_q_addr),
    .mem_wdata(mem_wdata), .mem_p_rdata(mem_p_rdata), .mem_q_rdata(mem_q_rdata),
    .busy(busy));
  dsa_core_store dsa_core_store_inst (.clk(clk), .mem_rd(mem_rd), .mem_we(mem_we),
    .mem_p_addr(mem_p_addr), .mem_q_addr(mem_q_addr), .mem_wdata(mem_wdata),
    .mem_p_rdata(mem_p_rdata), .mem_q_rdata(mem_q_rdata), .table_wr(table_wr));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ***********************************************
  // Helpers
  // ***********************************************
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // APB cycle; pready sampled at a rising edge, data taken at that same edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Field: units at a, sign flag on units, end flag on top digit
  task put_field(input int a, input logic [31:0] v, input int len, input logic neg);
    for (int i = 0; i < len; i++)
      dsa_core_store_inst.mem[a-i] = {(i == 0 && neg) || (i == len - 1), v[4*i+:4]};
  endtask

  task get_field(input int a, input int len, output logic [33:0] f);
    f = {dsa_core_store_inst.mem[a-len+1][4], dsa_core_store_inst.mem[a][4], 32'h0};
    for (int i = 0; i < len; i++) f[4*i+:4] = dsa_core_store_inst.mem[a-i][3:0];
  endtask

  // Start an operation and wait for busy to drop, t in clocks
  task run(input logic [7:0] op);
    apb(1'b1, dsa_pkg::REG_CTRL, {23'h0, 1'b1, op});
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (busy === 1'b1 && t < 20000);
  endtask

  task flags(input string nm, input logic [2:0] e);
    apb(1'b0, dsa_pkg::REG_STAT, 32'h0);
    check(nm, {28'h0, q[3:0]}, {28'h0, e, 1'b0});
    $display("test %s done", nm);
  endtask

  task pulse_sub(input int n);
    repeat (n) begin
      @(posedge clk) div_sub_ok <= 1'b1;
      @(posedge clk) div_sub_ok <= 1'b0;
    end
  endtask

  // Add or subtract case, expectations from the sign chart and timing formula
  task add_case(input string nm, input logic [7:0] op, input logic [31:0] pv, input int pl,
      input logic pn, input logic [31:0] qv, input int ql, input logic qn,
      input logic [31:0] rv, input logic rn, input logic rc, input logic ck);
    logic [33:0] f;
    int et;
    put_field(500, pv, pl, pn);
    put_field(600, qv, ql, qn);
    apb(1'b1, dsa_pkg::REG_PADDR, 32'd500);
    apb(1'b1, dsa_pkg::REG_QADDR, 32'd600);
    run(op);
    et = 100 * (13 + (ql < pl ? ql : pl) + 2 * pl + (rc ? 2 * pl : 0));
    check("add_time", {31'h0, t >= et - 3 && t <= et + 3}, 32'h1);
    get_field(500, pl, f);
    check("sum", f[31:0], rv);
    check("sum_flags", {30'h0, f[33:32]}, {30'h0, 1'b1, rn});
    get_field(600, ql, f);
    check("q_field", f[31:0], qv);
    chk_e = chk_e | ck;
    apb(1'b0, dsa_pkg::REG_STAT, 32'h0);
    check("recomp", {31'h0, q[5]}, {31'h0, rc});
    flags(nm, {chk_e, rv == 0, rv != 0 && !rn});
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      conclude();
    end
  end

  // ***********************************************
  // Test sequence
  // ***********************************************
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, console_rst, div_sub_ok, div_digit_end} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    chk_e = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    flags("reset", 3'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", {err, q[30:0]}, 32'h80000000);
    // Undecoded code must be flagged and must not start the walk
    apb(1'b1, dsa_pkg::REG_CTRL, 32'h00000199);
    apb(1'b0, dsa_pkg::REG_STAT, 32'h0);
    check("bad_op", {31'h0, q[6]}, 32'h1);
    check("bad_op_idle", {31'h0, q[0]}, 32'h0);
    apb(1'b1, dsa_pkg::REG_PADDR, 32'd500);
    apb(1'b0, dsa_pkg::REG_PADDR, 32'h0);
    check("paddr_rd", q, 32'd500);
    $display("test decode done");
    add_case("true_add", dsa_pkg::OP_ADD_FIELD, 32'h12, 2, 0, 32'h02, 2, 0, 32'h14, 0, 0, 0);
    add_case("comp_add", dsa_pkg::OP_ADD_FIELD, 32'h35, 2, 1, 32'h15, 2, 0, 32'h20, 1, 0, 0);
    add_case("recomp", dsa_pkg::OP_ADD_FIELD, 32'h15, 2, 0, 32'h35, 2, 1, 32'h20, 1, 1, 0);
    add_case("zero_sub", dsa_pkg::OP_SUB_FIELD, 32'h35, 2, 0, 32'h35, 2, 0, 32'h00, 0, 0, 0);
    add_case("long_q", dsa_pkg::OP_ADD_LITERAL, 32'h12, 2, 0, 32'h09400, 5, 0, 32'h12, 0, 0, 1);
    run(dsa_pkg::OP_BRANCH_ON_FLAG);
    chk_e = 1'b0;
    flags("branch_clear", 3'h1);
    add_case("carry_out", dsa_pkg::OP_ADD_FIELD, 32'h95, 2, 0, 32'h07, 2, 0, 32'h02, 0, 0, 1);
    add_case("short_q", dsa_pkg::OP_SUB_LITERAL, 32'h500, 3, 0, 32'h07, 2, 0, 32'h493, 0, 0, 0);
    run(dsa_pkg::OP_BRANCH_ON_FLAG);
    chk_e = 1'b0;
    add_case("unlike_sub", dsa_pkg::OP_SUB_FIELD, 32'h20, 2, 1, 32'h05, 2, 0, 32'h25, 1, 0, 0);
    run(dsa_pkg::OP_LOAD_DIVIDEND);
    flags("load_div", 3'h3);
    // Product area prefilled so that a missing clear shows
    for (int i = 80; i < 100; i++) dsa_core_store_inst.mem[i] = 5'h07;
    put_field(500, 32'h12, 2, 1);
    put_field(600, 32'h02, 2, 0);
    run(dsa_pkg::OP_PRODUCT);
    t = 0;
    for (int i = 80; i < 100; i++) t = t | dsa_core_store_inst.mem[i][3:0];
    check("prod_area", t, 32'h0);
    check("table_writes", {24'h0, table_wr}, 32'h0);
    apb(1'b0, dsa_pkg::REG_STAT, 32'h0);
    check("prod_sign", {31'h0, q[4]}, 32'h1);
    put_field(600, 32'h02, 2, 1);
    run(dsa_pkg::OP_QUOTIENT);
    apb(1'b0, dsa_pkg::REG_STAT, 32'h0);
    check("quot_sign", {31'h0, q[4]}, 32'h0);
    pulse_sub(9);
    flags("nine_subs", 3'h3);
    pulse_sub(1);
    flags("ten_subs", 3'h7);
    @(posedge clk) console_rst <= 1'b1;
    @(posedge clk) console_rst <= 1'b0;
    flags("console_rst", 3'h0);
    @(posedge clk) div_digit_end <= 1'b1;
    @(posedge clk) div_digit_end <= 1'b0;
    pulse_sub(10);
    flags("check_again", 3'h4);
    run(dsa_pkg::OP_BRANCH_UNLESS_FLAG);
    flags("unless_clear", 3'h0);
    conclude();
  end
endmodule // dsa_tb_top
`default_nettype wire
